/* ccs_pkg.sv */
// ccs_pkg: constants, types and special codes of the custom charger stimulus block
// assumes one 100 MHz clock and the register port of the serial host interface
package ccs_pkg;

  // ---------------------------------------------------------------
  // register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_S1_THR_PD  = 8'h43;
  localparam logic [7:0] OFS_S1_RATIO   = 8'h44;
  localparam logic [7:0] OFS_S2_TMR_SEL = 8'h45;
  localparam logic [7:0] OFS_S2_RESP    = 8'h46;
  localparam logic [3:0] RST_THR        = 4'h0;
  localparam logic [1:0] RST_PD         = 2'h0;
  localparam logic [2:0] RST_RATIO      = 3'h0;
  localparam logic [3:0] RST_RESP       = 4'h0;
  localparam logic [2:0] RST_STIM       = 3'h0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_PD    = 4;
  localparam int POS_TYPE  = 6;
  localparam int POS_TMR   = 3;
  localparam int POS_MAG   = 4;

  // ---------------------------------------------------------------
  // codes with a special meaning
  // ---------------------------------------------------------------
  localparam logic [3:0] THR_RSVD  = 4'hF;
  localparam logic [3:0] MAG_RSVD  = 4'hF;
  localparam logic [3:0] MAG_PD    = 4'h0;
  localparam logic [2:0] RAT_RSVD  = 3'h7;
  localparam logic [2:0] STIM_VRDY = 3'h0;
  localparam logic [2:0] STIM_VPRS = 3'h7;
  localparam logic [3:0] SEL_NONE  = 4'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TMR_UNIT_NS   = 1000000;
  localparam int CYC_PER_MS    = TMR_UNIT_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES   = 3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {K_REMOVE, K_VOLT, K_RES, K_DIV, K_SHORT, K_KEEP, K_RSVD} ccs_kind_t;
  typedef struct packed {logic [3:0] mag; logic [3:0] sel;} ccs_resp_t;
  typedef struct packed {
    logic vbus_ready;
    logic vbus_present;
    logic dp_above_th;
    logic dm_above_th;
    logic dp_above_floor;
  } ccs_cmp_t;

endpackage

/* ccs_regs.sv */
// ccs_regs: stage-1/2 stimulus configuration registers and the two-stage sequencer
// assumes the serial host decodes addresses into the register port below and
// that analog comparators and line drivers sit outside, fed by these outputs
`timescale 1ns/1ps
module ccs_regs #(
  parameter int CYC_MS = ccs_pkg::CYC_PER_MS
) (
  // clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  // register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata_ff,
  // settings held in neighbouring registers
  input  wire logic [2:0]          stage1_stimulus_select,
  input  wire logic [3:0]          stage1_response_select,
  input  wire logic [3:0]          stage1_response_magnitude,
  input  wire logic [3:0]          stage2_threshold,
  input  wire logic [1:0]          stage2_pulldown_current,
  input  wire logic [2:0]          stage2_divider_ratio,
  // sequencing engine
  input  wire logic                seq_start,
  input  wire logic                emulation_profile_cycle,
  input  wire logic                profile_legacy,
  output logic                     seq_busy_ff,
  output logic                     seq_done_ff,
  // comparator pins
  input  wire ccs_pkg::ccs_cmp_t   cmp_pin,
  output logic      [11:0]         threshold_mv_ff,
  // line drive
  output ccs_pkg::ccs_resp_t       drive_resp_ff,
  output ccs_pkg::ccs_kind_t       drive_kind_ff,
  output logic      [11:0]         drive_value_ff,
  output logic      [7:0]          pulldown_ua_ff,
  output logic      [6:0]          ratio_pct_ff
);

  // ---------------------------------------------------------------
  // decode tables
  // ---------------------------------------------------------------
  // threshold and voltage magnitude share one millivolt table
  function automatic logic [11:0] mv_of(input logic [3:0] c);
    case (c)
      4'h5:    mv_of = 12'h1F4;
      4'h6:    mv_of = 12'h258;
      4'h7:    mv_of = 12'h2BC;
      4'h8:    mv_of = 12'h320;
      4'h9:    mv_of = 12'h384;
      4'hA:    mv_of = 12'h578;
      4'hB:    mv_of = 12'h640;
      4'hC:    mv_of = 12'h708;
      4'hD:    mv_of = 12'h7D0;
      4'hE:    mv_of = 12'h898;
      default: mv_of = 12'h190;
    endcase
  endfunction

  // resistance in units of 100 ohm
  function automatic logic [11:0] res_of(input logic [3:0] c);
    case (c)
      4'h0:    res_of = 12'h012;
      4'h1:    res_of = 12'h064;
      4'h2:    res_of = 12'h096;
      4'h3:    res_of = 12'h0C8;
      4'h4:    res_of = 12'h0FA;
      4'h5:    res_of = 12'h12C;
      4'h6:    res_of = 12'h190;
      4'h7:    res_of = 12'h1AE;
      4'h8:    res_of = 12'h1F4;
      4'h9:    res_of = 12'h258;
      4'hA:    res_of = 12'h2EE;
      4'hB:    res_of = 12'h320;
      4'hC:    res_of = 12'h3E8;
      4'hD:    res_of = 12'h4B0;
      default: res_of = 12'h5DC;
    endcase
  endfunction

  // divider total in kilohm; pattern repeats every eight codes
  function automatic logic [11:0] div_of(input logic [3:0] c);
    case (c[2:0])
      3'h0:    div_of = 12'h05D;
      3'h1:    div_of = 12'h064;
      3'h2:    div_of = 12'h07D;
      3'h3:    div_of = c[3] ? 12'h096 : 12'h096;
      default: div_of = 12'h0C8;
    endcase
    if (c >= 4'hC) begin
      div_of = 12'h0C8;
    end
  endfunction

  function automatic ccs_pkg::ccs_kind_t kind_of(input logic [3:0] s);
    case (s)
      4'h0:                kind_of = ccs_pkg::K_REMOVE;
      4'h1, 4'h2, 4'h3:    kind_of = ccs_pkg::K_VOLT;
      4'h4, 4'h7, 4'hD:    kind_of = ccs_pkg::K_RES;
      4'h6, 4'h9, 4'hC:    kind_of = ccs_pkg::K_DIV;
      4'hA:                kind_of = ccs_pkg::K_SHORT;
      4'hE, 4'hF:          kind_of = ccs_pkg::K_KEEP;
      default:             kind_of = ccs_pkg::K_RSVD;
    endcase
  endfunction

  function automatic logic [6:0] ms_of(input logic [2:0] c);
    case (c)
      3'h0:    ms_of = 7'h00;
      3'h1:    ms_of = 7'h01;
      3'h2:    ms_of = 7'h05;
      3'h3:    ms_of = 7'h0A;
      3'h4:    ms_of = 7'h14;
      3'h5:    ms_of = 7'h28;
      3'h6:    ms_of = 7'h50;
      default: ms_of = 7'h64;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // stored fields
  // ---------------------------------------------------------------
  logic [3:0] s1_thr_ff;
  logic [1:0] s1_pd_ff;
  logic [2:0] s1_ratio_ff;
  logic       s2_type_ff;
  logic [2:0] s2_tmr_ff;
  logic [2:0] s2_stim_ff;
  logic [3:0] s2_mag_ff;
  logic [3:0] s2_sel_ff;

  // write side; each field with reserved codes (threshold, ratio, stimulus, magnitude, select) is checked on its own
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_thr_ff   <= ccs_pkg::RST_THR;
      s1_pd_ff    <= ccs_pkg::RST_PD;
      s1_ratio_ff <= ccs_pkg::RST_RATIO;
      s2_type_ff  <= 1'b0;
      s2_tmr_ff   <= 3'h0;
      s2_stim_ff  <= ccs_pkg::RST_STIM;
      s2_mag_ff   <= ccs_pkg::RST_RESP;
      s2_sel_ff   <= ccs_pkg::RST_RESP;
    end else if (ce && reg_wr) begin
      if (reg_addr == ccs_pkg::OFS_S1_THR_PD) begin
        s1_pd_ff <= reg_wdata[ccs_pkg::POS_PD +: 2];
        if (reg_wdata[3:0] != ccs_pkg::THR_RSVD) begin
          s1_thr_ff <= reg_wdata[3:0];
        end
      end else if (reg_addr == ccs_pkg::OFS_S1_RATIO) begin
        if (reg_wdata[2:0] != ccs_pkg::RAT_RSVD) begin
          s1_ratio_ff <= reg_wdata[2:0];
        end
      end else if (reg_addr == ccs_pkg::OFS_S2_TMR_SEL) begin
        s2_type_ff <= reg_wdata[ccs_pkg::POS_TYPE];
        s2_tmr_ff  <= reg_wdata[ccs_pkg::POS_TMR +: 3];
        if (reg_wdata[2:1] != 2'h2) begin
          s2_stim_ff <= reg_wdata[2:0];
        end
      end else if (reg_addr == ccs_pkg::OFS_S2_RESP) begin
        if (reg_wdata[ccs_pkg::POS_MAG +: 4] != ccs_pkg::MAG_RSVD) begin
          s2_mag_ff <= reg_wdata[ccs_pkg::POS_MAG +: 4];
        end
        if (kind_of(reg_wdata[3:0]) != ccs_pkg::K_RSVD) begin
          s2_sel_ff <= reg_wdata[3:0];
        end
      end
    end
  end

  // read side; unimplemented bits and unknown offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_ff <= 8'h00;
    end else if (ce && reg_rd) begin
      if (reg_addr == ccs_pkg::OFS_S1_THR_PD) begin
        reg_rdata_ff <= {2'h0, s1_pd_ff, s1_thr_ff};
      end else if (reg_addr == ccs_pkg::OFS_S1_RATIO) begin
        reg_rdata_ff <= {5'h00, s1_ratio_ff};
      end else if (reg_addr == ccs_pkg::OFS_S2_TMR_SEL) begin
        reg_rdata_ff <= {1'b0, s2_type_ff, s2_tmr_ff, s2_stim_ff};
      end else if (reg_addr == ccs_pkg::OFS_S2_RESP) begin
        reg_rdata_ff <= {s2_mag_ff, s2_sel_ff};
      end else begin
        reg_rdata_ff <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // comparator synchroniser
  // ---------------------------------------------------------------
  ccs_pkg::ccs_cmp_t sync1_ff;
  ccs_pkg::ccs_cmp_t sync2_ff;
  ccs_pkg::ccs_cmp_t sync3_ff;
  ccs_pkg::ccs_cmp_t cmp_ff;

  // a change counts only once stages two and three agree, which rejects chatter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      cmp_ff   <= '0;
    end else if (ce) begin
      sync1_ff <= cmp_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      for (int i = 0; i < $bits(ccs_pkg::ccs_cmp_t); i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          cmp_ff[i] <= sync3_ff[i];
        end
      end
    end
  end

  // stimulus met for a given select code
  function automatic logic stim_met(input logic [2:0] s, input ccs_pkg::ccs_cmp_t c);
    case (s)
      3'h0:       stim_met = c.vbus_ready;
      3'h1, 3'h6: stim_met = c.dp_above_th;
      3'h2:       stim_met = !c.dp_above_th && c.dp_above_floor;
      3'h3:       stim_met = c.dm_above_th;
      3'h7:       stim_met = c.vbus_present;
      default:    stim_met = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_DET1, ST_DET2, ST_WAIT, ST_HOLD, ST_DONE} ccs_st_t;

  ccs_st_t           state_ff;
  ccs_st_t           nxt_state;
  logic [23:0]       tmr_ff;
  logic [23:0]       nxt_tmr;
  logic              nxt_apply;
  ccs_pkg::ccs_resp_t nxt_resp;
  logic [2:0]        cur_stim;
  logic [3:0]        cur_thr;
  logic [23:0]       tmr_load;

  // 100 ms fits in 24 bits at the nominal rate
  assign tmr_load = 24'(32'(ms_of(s2_tmr_ff)) * CYC_MS);
  assign cur_stim = (state_ff == ST_DET1) ? stage1_stimulus_select : s2_stim_ff;
  assign cur_thr  = (state_ff == ST_DET1) ? s1_thr_ff : stage2_threshold;

  // stage 2 only starts watching once stage 1 has responded
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr   = tmr_ff;
    nxt_apply = 1'b0;
    nxt_resp  = '{mag: s2_mag_ff, sel: s2_sel_ff};
    case (state_ff)
      ST_IDLE: begin
        if (seq_start) begin
          nxt_state = ST_DET1;
        end
      end
      ST_DET1: begin
        if (stim_met(stage1_stimulus_select, cmp_ff)) begin
          nxt_apply = 1'b1;
          nxt_resp  = '{mag: stage1_response_magnitude, sel: stage1_response_select};
          nxt_state = ST_DET2;
        end
      end
      ST_DET2: begin
        if (stim_met(s2_stim_ff, cmp_ff)) begin
          nxt_tmr = tmr_load;
          if (s2_type_ff) begin
            nxt_apply = 1'b1;
            nxt_state = ST_HOLD;
          end else begin
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (tmr_ff == 24'h000000) begin
          nxt_apply = 1'b1;
          nxt_state = ST_DONE;
        end else begin
          nxt_tmr = tmr_ff - 24'h000001;
        end
      end
      ST_HOLD: begin
        if (tmr_ff == 24'h000000) begin
          if (!stim_met(s2_stim_ff, cmp_ff)) begin
            nxt_apply = 1'b1;
            nxt_resp  = '{mag: s2_mag_ff, sel: ccs_pkg::SEL_NONE};
          end
          nxt_state = ST_DONE;
        end else begin
          nxt_tmr = tmr_ff - 24'h000001;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state and timer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      tmr_ff   <= 24'h000000;
    end else if (ce) begin
      state_ff <= nxt_state;
      tmr_ff   <= nxt_tmr;
    end
  end

  // sequencer status
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seq_busy_ff <= 1'b0;
      seq_done_ff <= 1'b0;
    end else if (ce) begin
      seq_busy_ff <= (nxt_state != ST_IDLE) && (nxt_state != ST_DONE);
      seq_done_ff <= (nxt_state == ST_DONE);
    end
  end

  // ---------------------------------------------------------------
  // comparator reference
  // ---------------------------------------------------------------
  // bus stimuli leave the last reference in place, so the comparator never glitches
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      threshold_mv_ff <= 12'h190;
    end else if (ce && (state_ff == ST_DET1 || state_ff == ST_DET2)) begin
      if (cur_stim != ccs_pkg::STIM_VRDY && cur_stim != ccs_pkg::STIM_VPRS
          && !profile_legacy) begin
        threshold_mv_ff <= (cur_thr == 4'h3) ? 12'h12C : mv_of(cur_thr);
      end
    end
  end

  // ---------------------------------------------------------------
  // line drive
  // ---------------------------------------------------------------
  ccs_pkg::ccs_kind_t apply_kind;
  logic               apply_legacy;

  assign apply_kind   = kind_of(nxt_resp.sel);
  assign apply_legacy = emulation_profile_cycle && profile_legacy;

  // response shape and its decoded magnitude
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      drive_resp_ff  <= '0;
      drive_kind_ff  <= ccs_pkg::K_REMOVE;
      drive_value_ff <= 12'h000;
    end else if (ce && nxt_apply) begin
      drive_resp_ff <= nxt_resp;
      drive_kind_ff <= apply_kind;
      if (apply_kind == ccs_pkg::K_VOLT) begin
        drive_value_ff <= (nxt_resp.mag == ccs_pkg::MAG_PD) ? 12'h000 : mv_of(nxt_resp.mag);
      end else if (apply_kind == ccs_pkg::K_RES) begin
        drive_value_ff <= res_of(nxt_resp.mag);
      end else if (apply_kind == ccs_pkg::K_DIV) begin
        drive_value_ff <= div_of(nxt_resp.mag);
      end else begin
        drive_value_ff <= 12'h000;
      end
    end
  end

  // pull-down sink; legacy profiles leave it untouched during an emulation profile cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pulldown_ua_ff <= 8'h0A;
    end else if (ce && nxt_apply && !apply_legacy && apply_kind == ccs_pkg::K_VOLT
                 && nxt_resp.mag == ccs_pkg::MAG_PD) begin
      case (state_ff == ST_DET1 ? s1_pd_ff : stage2_pulldown_current)
        2'h0:    pulldown_ua_ff <= 8'h0A;
        2'h1:    pulldown_ua_ff <= 8'h32;
        2'h2:    pulldown_ua_ff <= 8'h64;
        default: pulldown_ua_ff <= 8'h96;
      endcase
    end
  end

  // divider ratio in percent; standard profiles leave it untouched
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ratio_pct_ff <= 7'h19;
    end else if (ce && nxt_apply && apply_legacy && apply_kind == ccs_pkg::K_DIV) begin
      case (state_ff == ST_DET1 ? s1_ratio_ff : stage2_divider_ratio)
        3'h0:    ratio_pct_ff <= 7'h19;
        3'h1:    ratio_pct_ff <= 7'h21;
        3'h2:    ratio_pct_ff <= 7'h28;
        3'h3:    ratio_pct_ff <= 7'h32;
        3'h4:    ratio_pct_ff <= 7'h36;
        3'h5:    ratio_pct_ff <= 7'h3C;
        default: ratio_pct_ff <= 7'h42;
      endcase
    end
  end

endmodule

/* ccs_regs_assertions.sv */
// ccs_regs_chk: port-level checks of the stimulus configuration block
// assumes it is bound into ccs_regs and sees only that module's ports
`timescale 1ns/1ps
module ccs_regs_chk (
  // clock, reset, enable
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               ce,
  // register port
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata_ff,
  // sequencing and profile
  input wire logic               seq_start,
  input wire logic               emulation_profile_cycle,
  input wire logic               profile_legacy,
  input wire logic               seq_busy_ff,
  input wire logic               seq_done_ff,
  // outputs under watch
  input wire logic [11:0]        threshold_mv_ff,
  input wire ccs_pkg::ccs_resp_t drive_resp_ff,
  input wire ccs_pkg::ccs_kind_t drive_kind_ff,
  input wire logic [7:0]         pulldown_ua_ff,
  input wire logic [6:0]         ratio_pct_ff
);
  // ------------------------------------------------------------
  // register readback
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a read taken at this edge
  logic rd_now;
  assign rd_now = ce && reg_rd;

  unmapped_read_a: assert property (rd_now && !(reg_addr inside {[8'h43:8'h46]})
    |=> reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
  stage_layout_a: assert property (rd_now && reg_addr == 8'h45
    |=> !reg_rdata_ff[7] && reg_rdata_ff[2:1] != 2'b10) else $error("stage select readback bad");
  thr_reserved_a: assert property (rd_now && reg_addr == 8'h43
    |=> reg_rdata_ff[7:6] == 2'h0 && reg_rdata_ff[3:0] != 4'hF) else $error("threshold bad");
  ratio_reserved_a: assert property (rd_now && reg_addr == 8'h44
    |=> reg_rdata_ff[7:3] == 5'h00 && reg_rdata_ff[2:0] != 3'h7) else $error("ratio bad");
  resp_reserved_a: assert property (rd_now && reg_addr == 8'h46
    |=> !(reg_rdata_ff[3:0] inside {4'h5, 4'h8, 4'hB}) && reg_rdata_ff[7:4] != 4'hF)
    else $error("response readback bad");

  // ------------------------------------------------------------
  // profile gating, sequencing and select decode
  // ------------------------------------------------------------
  ratio_gate_a: assert property ($changed(ratio_pct_ff) && $past(rst_b)
    |-> $past(emulation_profile_cycle && profile_legacy) && ratio_pct_ff inside {33, 40, 50, 54, 60, 66, 25})
    else $error("ratio moved outside legacy cycle");
  thr_gate_a: assert property ($changed(threshold_mv_ff) && $past(rst_b)
    |-> !$past(profile_legacy) && threshold_mv_ff != 12'h000) else $error("threshold moved in legacy");
  pd_gate_a: assert property ($changed(pulldown_ua_ff) && $past(rst_b)
    |-> !$past(emulation_profile_cycle && profile_legacy) && pulldown_ua_ff inside {10, 50, 100, 150})
    else $error("pull-down current moved wrongly");
  done_pulse_a: assert property (seq_done_ff |=> !seq_done_ff && !seq_busy_ff)
    else $error("done not a single idle pulse");
  start_busy_a: assert property (seq_start && ce && !seq_busy_ff && !seq_done_ff
    |=> seq_busy_ff) else $error("start not taken");
  kind_match_a: assert property (drive_resp_ff.sel inside {4'h6, 4'h9, 4'hC}
    |-> drive_kind_ff == ccs_pkg::K_DIV) else $error("divider select not decoded");
endmodule

/* ccs_pd_model.sv */
// ccs_pd_model: portable device on the data lines, seen through the comparators
// assumes the bench tells it which levels to show and whether to answer slowly
`timescale 1ns/1ps
module ccs_pd_model (
  // clock
  input  wire logic              clk,
  // control from the bench
  input  wire logic              slow,
  input  wire ccs_pkg::ccs_cmp_t want,
  // comparator view of the lines
  output ccs_pkg::ccs_cmp_t      cmp_pin
);
  int                cnt  = 0;
  ccs_pkg::ccs_cmp_t last = '0;
  initial cmp_pin = '0;
  // lines settle a few cycles late; slow mimics a lazy device
  always @(posedge clk) begin
    if (want !== last) begin
      cnt  = slow ? 8 : 2;
      last = want;
    end else if (cnt > 0) cnt = cnt - 1;
    if (cnt == 1) cmp_pin <= last;
  end
endmodule

/* tb_custom_charger_stimulus_config.sv */
// tb_custom_charger_stimulus_config: self-checking bench of the stimulus block
// assumes package, design, checker and device model compiled first
`timescale 1ns/1ps
module tb_custom_charger_stimulus_config;
  localparam int CYC = 10;
  logic clk = 0, rst_b = 0, ce = 1, reg_wr = 0, reg_rd = 0, seq_start = 0, slow = 0;
  logic emulation_profile_cycle = 0, profile_legacy = 0, seq_busy_ff, seq_done_ff;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff, pulldown_ua_ff;
  logic [2:0] stage1_stimulus_select = 3'h0, stage2_divider_ratio = 3'h0;
  logic [3:0] stage1_response_select = 4'hA, stage1_response_magnitude = 4'h0;
  logic [3:0] stage2_threshold = 4'h0;
  logic [1:0] stage2_pulldown_current = 2'h0;
  logic [11:0] threshold_mv_ff, drive_value_ff;
  logic [6:0] ratio_pct_ff;
  ccs_pkg::ccs_cmp_t cmp_pin, want = '0;
  ccs_pkg::ccs_resp_t drive_resp_ff;
  ccs_pkg::ccs_kind_t drive_kind_ff;
  int miscompares = 0, checked = 0;
  logic [7:0] m [4] = '{default: 8'h00};

  always #5 clk = ~clk;

  ccs_regs #(.CYC_MS(CYC)) i_ccs_regs (.clk, .rst_b, .ce, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata_ff, .stage1_stimulus_select, .stage1_response_select,
    .stage1_response_magnitude, .stage2_threshold, .stage2_pulldown_current,
    .stage2_divider_ratio, .seq_start, .emulation_profile_cycle, .profile_legacy,
    .seq_busy_ff, .seq_done_ff, .cmp_pin, .threshold_mv_ff, .drive_resp_ff, .drive_kind_ff,
    .drive_value_ff, .pulldown_ua_ff, .ratio_pct_ff);
  ccs_pd_model i_ccs_pd_model (.clk, .slow, .want, .cmp_pin);

  // ------------------------------------------------------------
  // bus tasks and expectation functions
  // ------------------------------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (exp !== got) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // register image: reserved codes leave the old field in place
  function automatic logic [7:0] nv(int i, logic [7:0] o, logic [7:0] d);
    case (i)
      0: return {2'h0, d[5:4], (d[3:0] == 4'hF) ? o[3:0] : d[3:0]};
      1: return {5'h00, (d[2:0] == 3'h7) ? o[2:0] : d[2:0]};
      2: return {1'b0, d[6:3], (d[2:1] == 2'b10) ? o[2:0] : d[2:0]};
      default: return {(d[7:4] == 4'hF) ? o[7:4] : d[7:4],
                       (d[3:0] inside {4'h5, 4'h8, 4'hB}) ? o[3:0] : d[3:0]};
    endcase
  endfunction
  task automatic wrm(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a >= 8'h43 && a <= 8'h46) m[a - 8'h43] = nv(a - 8'h43, m[a - 8'h43], d);
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    q = reg_rdata_ff;
  endtask
  function automatic int mv(logic [3:0] c);
    int t [16] = '{400,400,400,400,400,500,600,700,800,900,1400,1600,1800,2000,2200,0};
    return t[c];
  endfunction
  function automatic int ms(logic [2:0] c);
    int t [8] = '{0, 1, 5, 10, 20, 40, 80, 100};
    return t[c];
  endfunction
  function automatic ccs_pkg::ccs_kind_t kd(logic [3:0] s);
    case (s)
      4'h0: return ccs_pkg::K_REMOVE;
      4'h1, 4'h2, 4'h3: return ccs_pkg::K_VOLT;
      4'h4, 4'h7, 4'hD: return ccs_pkg::K_RES;
      4'h6, 4'h9, 4'hC: return ccs_pkg::K_DIV;
      4'hA: return ccs_pkg::K_SHORT;
      default: return ccs_pkg::K_KEEP;
    endcase
  endfunction
  function automatic int val(logic [3:0] s, logic [3:0] c);
    int r [16] = '{18,100,150,200,250,300,400,430,500,600,750,800,1000,1200,1500,0};
    int v [4] = '{93, 100, 125, 150};
    case (kd(s))
      ccs_pkg::K_VOLT: return (c == 4'h0) ? 0 : mv(c);
      ccs_pkg::K_RES: return r[c];
      ccs_pkg::K_DIV: return (c[2] || c >= 4'hC) ? 200 : v[c[1:0]];
      default: return 0;
    endcase
  endfunction
  // data-line comparator levels that meet a stage-2 stimulus code
  function automatic logic [4:0] pat(logic [2:0] s);
    case (s)
      3'h1, 3'h6: return 5'b00101;
      3'h2: return 5'b00001;
      3'h3: return 5'b00010;
      default: return 5'b00000;
    endcase
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] d, q;
    logic [3:0] sel, mag, th;
    logic [2:0] tc, st2, rt;
    logic [1:0] pd;
    logic ty, drop, leg, cyc;
    int a, i, t, t1, t2, t3, ethr, epd, erat;
    logic [15:0] cw [7] = '{16'h433F, 16'h4407, 16'h457C, 16'h450D, 16'h46F5, 16'h463B, 16'h4648};
    logic [2:0] stt [6] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h0, 3'h7};
    logic [3:0] sels [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD};
    int pdt [4] = '{10, 50, 100, 150};
    int rtt [7] = '{25, 33, 40, 50, 54, 60, 66};
    void'($urandom(25));
    ethr = 400; epd = 10; erat = 25;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    chk("threshold at reset", 16'd400, threshold_mv_ff);
    // reserved-code corners, then random bytes
    for (i = 0; i < 40; i++) begin
      a = (i < 7) ? cw[i][15:8] : $urandom_range(8'h47, 8'h42);
      d = (i < 7) ? cw[i][7:0] : 8'($urandom);
      wrm(8'(a), d);
      rd(8'(a), q);
      chk("register readback", (a >= 8'h43 && a <= 8'h46) ? m[a - 8'h43] : 8'h00, q);
    end
    // stage-1 short, then stage-2 response per timer code and type
    for (i = 0; i < 16; i++) begin
      tc = i[2:0]; ty = i[3]; st2 = stt[i % 6];
      sel = sels[$urandom_range(8)]; mag = 4'($urandom_range(14));
      if (i == 0 || i == 9) begin sel = 4'h1; mag = 4'h0; end
      th = 4'($urandom_range(14)); pd = 2'($urandom); rt = 3'($urandom_range(6));
      leg = 1'($urandom); cyc = (i == 0) ? 1'b0 : 1'($urandom);
      drop = ty && tc >= 3'h2 && st2 != 3'h0 && st2 != 3'h7 && 1'($urandom);
      want <= 5'b11000 | pat(st2);
      slow <= 1'($urandom);
      stage1_stimulus_select <= 1'($urandom) ? 3'h7 : 3'h0;
      stage2_threshold <= th; stage2_pulldown_current <= pd; stage2_divider_ratio <= rt;
      emulation_profile_cycle <= cyc; profile_legacy <= leg;
      wrm(8'h45, {1'b0, ty, tc, st2});
      wrm(8'h46, {mag, sel});
      // slow device answer plus synchroniser
      repeat (12) @(posedge clk);
      if (st2 != 3'h0 && st2 != 3'h7 && !leg) ethr = (th == 4'h3) ? 300 : mv(th);
      if (kd(sel) == ccs_pkg::K_VOLT && mag == 4'h0 && !(cyc && leg)) epd = pdt[pd];
      if (kd(sel) == ccs_pkg::K_DIV && cyc && leg) erat = rtt[rt];
      seq_start <= 1'b1;
      @(posedge clk);
      seq_start <= 1'b0;
      t1 = -1; t2 = -1; t3 = -1;
      for (t = 0; t < 1200 && t3 < 0; t++) begin
        @(posedge clk);
        if (t1 < 0 && drive_kind_ff === ccs_pkg::K_SHORT) t1 = t;
        if (t1 >= 0 && t2 < 0 && drive_resp_ff === {mag, sel}) begin
          t2 = t;
          if (drop) want <= 5'b11000;
        end
        if (seq_done_ff === 1'b1) t3 = t;
      end
      if (t3 < 0) begin
        miscompares++;
        $display("wrong value sequence end expected done seen timeout");
        stop_test;
      end
      chk("stage one short", 1'b1, t1 >= 0);
      if (ty) chk("apply at once", 1'b1, t1 >= 0 && t2 >= t1 && t2 - t1 <= 3);
      else chk("apply after wait", 1'b1, t2 - t1 >= ms(tc) * CYC && t2 - t1 <= ms(tc) * CYC + 4);
      chk("timer length", 1'b1, t3 - t1 >= ms(tc) * CYC && t3 - t1 <= ms(tc) * CYC + 4);
      chk("response select", drop ? 4'h0 : sel, drive_resp_ff.sel);
      if (!drop) chk("response kind", kd(sel), drive_kind_ff);
      if (!drop) chk("response value", 16'(val(sel, mag)), drive_value_ff);
      chk("threshold", 16'(ethr), threshold_mv_ff);
      chk("pull-down current", 16'(epd), pulldown_ua_ff);
      chk("divider ratio", 16'(erat), ratio_pct_ff);
    end
    stop_test;
  end
endmodule

bind ccs_regs ccs_regs_chk i_ccs_regs_chk (.clk, .rst_b, .ce, .reg_addr, .reg_rd, .reg_rdata_ff,
  .seq_start, .emulation_profile_cycle, .profile_legacy, .seq_busy_ff, .seq_done_ff,
  .threshold_mv_ff, .drive_resp_ff, .drive_kind_ff, .pulldown_ua_ff, .ratio_pct_ff);
